// *** common/fcw_pkg.sv ***
package fcw_pkg;

  // Core clock and the self-timed register update time.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned REG_UPDATE_TIME_NS = 40000;
  localparam int unsigned REG_UPDATE_CYCLES =
    (REG_UPDATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command codes seen on the serial input.
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15;
  localparam logic [7:0] OP_ENTER_WIDE = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE = 8'hE9;

  // Frame lengths in serial bits, opcode included, and the bit count saturation limit.
  localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_SR_BITS = 5'h10;
  localparam logic [4:0] FRAME_CR_BITS = 5'h18;
  localparam logic [4:0] FRAME_CNT_MAX = 5'h1F;

  // Status register field positions.
  localparam int unsigned SR_LOCK_BIT = 7;
  localparam int unsigned SR_QE_BIT = 6;
  localparam int unsigned SR_BP_LSB = 2;
  localparam int unsigned SR_BP_MSB = 5;
  localparam int unsigned SR_LATCH_BIT = 1;
  localparam int unsigned SR_BUSY_BIT = 0;

  // Configuration register field positions.
  localparam int unsigned CR_DC_LSB = 6;
  localparam int unsigned CR_DC_MSB = 7;
  localparam int unsigned CR_WIDE_BIT = 5;
  localparam int unsigned CR_PBE_BIT = 4;
  localparam int unsigned CR_TB_BIT = 3;
  localparam int unsigned CR_ODS_LSB = 0;
  localparam int unsigned CR_ODS_MSB = 2;

  // Reset values and the two reserved drive codes.
  localparam logic [2:0] ODS_RESET = 3'h7;
  localparam logic [1:0] DC_RESET = 2'h0;
  localparam logic [3:0] BP_RESET = 4'h0;
  localparam logic [2:0] ODS_RSVD_A = 3'h0;
  localparam logic [2:0] ODS_RSVD_B = 3'h4;

  // Dummy clock tables, four bits per code, code 3 in the top nibble.
  localparam logic [15:0] DUMMY_FAST_TBL = 16'hA868;
  localparam logic [15:0] DUMMY_DUAL_IO_TBL = 16'hA864;
  localparam logic [15:0] DUMMY_QUAD_IO_TBL = 16'hA846;

  typedef enum logic [1:0] {
    FCW_IDLE = 2'b01,
    FCW_UPDATING = 2'b10
  } fcw_state_t;

endpackage

// *** core/fcw_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcw_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{RESET_VAL}};
      q <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // fcw_sync
`default_nettype wire

// *** core/fcw_top.sv ***
// Contract
// - Three-bit volatile drive code, codes 000 and 100 reserved, default 111.
// - Drive, top/bottom and preamble fields change only via write-registers.
// - Top/bottom select is one-time programmable, default 0 top, 1 bottom.
// - Preamble enable defaults to 0; when 1 preamble drives dummy cycles.
// - Enter-wide sets wide address flag, exit-wide or power-off clears it.
// - Single, dual, quad output reads take dummy 8,6,8,10 by code.
// - Dual I/O reads take dummy 4,6,8,10 by code.
// - Quad I/O reads take dummy 6,4,8,10 by code.
// - Write-registers updates protect level, quad enable, lock; not latch or busy.
// - Frame is chip select low, opcode, status byte, optional config byte.
// - Chip select must rise at exactly 8 or 16 data bits, else rejected.
// - Valid frame starts timed update, busy 1, then busy and latch cleared.
// - Busy flag may be read back during the update cycle.
// - Lock 0, or lock 1 with pin high, lets write-registers change protection.
// - Lock 1 with pin low rejects every write-registers even with latch set, unless quad enable or quad peripheral mode is on.
// - Lock 1 and pin low is hardware protect mode, protection bits read-only.
// - Pin high leaves hardware protect; pin held high means software only.
// - Quad enable or quad peripheral mode disables hardware protect mode.
// - Program and erase into the protected area are refused.
// - Status layout lock, quad, level[3:0], latch, busy; upper six non-volatile.
// - With write latch 0, program, erase and write-registers are ignored.
`timescale 1ns/1ns
`default_nettype none
module fcw_top #(
  parameter int unsigned UPDATE_CYCLES = fcw_pkg::REG_UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  input wire logic write_protect_pin,
  input wire logic quad_peripheral_mode,
  input wire logic pe_req,
  input wire logic pe_hits_protected,
  output logic pe_grant,
  output logic pe_refuse,
  output logic busy_flag,
  output logic write_latch,
  output logic [3:0] block_protect_level,
  output logic quad_enable,
  output logic reg_write_lock,
  output logic hw_protect_mode,
  output logic protect_from_bottom,
  output logic preamble_enable,
  output logic wide_address_flag,
  output logic [2:0] drive_strength_code,
  output logic [1:0] dummy_count_sel,
  output logic [3:0] dummy_fast,
  output logic [3:0] dummy_dual_io,
  output logic [3:0] dummy_quad_io
);
  import fcw_pkg::*;
  // The timer is 24 bits wide and needs at least two busy cycles.
  if (UPDATE_CYCLES < 2 || UPDATE_CYCLES > 24'hFFFFFF) begin : g_bad_update_cycles
    $error("UPDATE_CYCLES must lie between 2 and 2**24-1");
  end
  localparam logic [23:0] UPD_LAST = 24'(UPDATE_CYCLES - 1);

  // Picks one dummy count out of a packed four-entry table.
  function automatic logic [3:0] dummy_lookup(input logic [15:0] tbl, input logic [1:0] sel);
    dummy_lookup = tbl[{sel, 2'b00} +: 4];
  endfunction
  logic [1:0] rst_pipe_q;
  logic rst_n_q;
  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_pipe_q[1];
  // Link side, clocked by the host's serial clock.
  logic first_q;
  logic [4:0] bit_cnt_q;
  logic [23:0] shift_q;
  logic [15:0] regs_link;
  logic [1:0] rd_mode_q;
  logic [1:0] rd_mode;
  logic [2:0] out_idx;
  logic [7:0] out_byte;

  // Chip select high arms the next frame; the first edge restarts the count.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Bits stay put after chip select rises, so the core can read them.
  always_ff @(posedge sclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 24'h000000;
    end else if (first_q) begin
      bit_cnt_q <= 5'h01;
      shift_q <= {23'h000000, si};
    end else begin
      if (bit_cnt_q != FRAME_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      shift_q <= {shift_q[22:0], si};
    end
  end

  // Register snapshot for readback; bits change rarely, so per-bit sync is enough.
  fcw_sync #(.WIDTH(16), .RESET_VAL(1'b0)) u_regs_sync (
    .clk(sclk),
    .rst_n(rst_n_q),
    .d({reg_write_lock, quad_enable, block_protect_level, write_latch, busy_flag,
        dummy_count_sel, wide_address_flag, preamble_enable, protect_from_bottom,
        drive_strength_code}),
    .q(regs_link)
  );

  // Read commands are decoded live at the eighth bit, then held.
  always_comb begin
    rd_mode = rd_mode_q;
    if (bit_cnt_q == FRAME_CMD_BITS) begin
      rd_mode = {shift_q[7:0] == OP_READ_CONFIG, shift_q[7:0] == OP_READ_STATUS};
    end
    out_idx = 3'(3'h7 - bit_cnt_q[2:0]);
    out_byte = rd_mode[1] ? regs_link[7:0] : regs_link[15:8];
  end

  // Readback shifts out on falling edges, repeating the byte until the bit count saturates at 31, then holding bit 0 until deselect.
  always_ff @(negedge sclk or negedge rst_n_q or posedge cs_n) begin
    if (!rst_n_q) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
      rd_mode_q <= 2'b00;
    end else if (cs_n) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
      rd_mode_q <= 2'b00;
    end else if (bit_cnt_q >= FRAME_CMD_BITS && rd_mode != 2'b00) begin
      rd_mode_q <= rd_mode;
      so_oe <= 1'b1;
      so_o <= out_byte[out_idx];
    end
  end

  // Core side.
  logic cs_s;
  logic wp_s;
  logic cs_prev_q;
  logic frame_done;
  logic [4:0] fr_cnt;
  logic [7:0] fr_op;
  logic [7:0] fr_sr;
  logic [7:0] fr_cr;
  logic idle;
  logic wr_valid;
  logic wr_done;
  fcw_state_t state_q;
  logic [23:0] upd_cnt_q;
  logic [7:0] pend_sr_q;
  logic [7:0] pend_cr_q;
  logic pend_has_cr_q;

  fcw_sync #(.WIDTH(2), .RESET_VAL(1'b1)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n_q),
    .d({cs_n, write_protect_pin}),
    .q({cs_s, wp_s})
  );

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
    end
  end

  // Frame words are stable from the synced rise of chip select to the next frame.
  always_comb begin
    frame_done = cs_s && !cs_prev_q;
    fr_cnt = bit_cnt_q;
    fr_op = shift_q[7:0];
    fr_sr = 8'h00;
    fr_cr = 8'h00;
    if (fr_cnt == FRAME_SR_BITS) begin
      fr_op = shift_q[15:8];
      fr_sr = shift_q[7:0];
    end else if (fr_cnt == FRAME_CR_BITS) begin
      fr_op = shift_q[23:16];
      fr_sr = shift_q[15:8];
      fr_cr = shift_q[7:0];
    end
  end

  assign idle = (state_q == FCW_IDLE);
  assign wr_done = (state_q == FCW_UPDATING) && (upd_cnt_q == 24'h000000);
  // Needs the latch, an 8 or 16 data bit boundary and no hardware protect.
  assign wr_valid = frame_done && idle && (fr_op == OP_WRITE_REGS) &&
                    (fr_cnt == FRAME_SR_BITS || fr_cnt == FRAME_CR_BITS) &&
                    write_latch &&
                    !hw_protect_mode;

  // Update timer; every other command except the two register reads is ignored while it runs.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= FCW_IDLE;
      upd_cnt_q <= 24'h000000;
    end else begin
      unique case (state_q)
        FCW_IDLE: begin
          if (wr_valid) begin
            state_q <= FCW_UPDATING;
            upd_cnt_q <= UPD_LAST;
          end
        end
        FCW_UPDATING: begin
          if (upd_cnt_q == 24'h000000) begin
            state_q <= FCW_IDLE;
          end else begin
            upd_cnt_q <= upd_cnt_q - 24'h000001;
          end
        end
      endcase
    end
  end

  // Captured frame data waits here until the timed cycle ends.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_sr_q <= 8'h00;
      pend_cr_q <= 8'h00;
      pend_has_cr_q <= 1'b0;
    end else if (wr_valid) begin
      pend_sr_q <= fr_sr;
      pend_cr_q <= fr_cr;
      pend_has_cr_q <= (fr_cnt == FRAME_CR_BITS);
    end
  end

  assign busy_flag = (state_q == FCW_UPDATING);
  // Non-volatile status bits; reset stands in for the factory state.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_write_lock <= 1'b0;
      quad_enable <= 1'b0;
      block_protect_level <= BP_RESET;
    end else if (wr_done) begin
      reg_write_lock <= pend_sr_q[SR_LOCK_BIT];
      quad_enable <= pend_sr_q[SR_QE_BIT];
      block_protect_level <= pend_sr_q[SR_BP_MSB:SR_BP_LSB];
    end
  end

  // Latch set by write-enable, cleared at completion; the set has priority.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_latch <= 1'b0;
    end else if (frame_done && idle && fr_cnt == FRAME_CMD_BITS && fr_op == OP_WRITE_ENABLE) begin
      write_latch <= 1'b1;
    end else if (wr_done) begin
      write_latch <= 1'b0;
    end
  end

  // Configuration fields; only a 16 data bit frame touches them.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dummy_count_sel <= DC_RESET;
      preamble_enable <= 1'b0;
      protect_from_bottom <= 1'b0;
      drive_strength_code <= ODS_RESET;
    end else if (wr_done && pend_has_cr_q) begin
      dummy_count_sel <= pend_cr_q[CR_DC_MSB:CR_DC_LSB];
      preamble_enable <= pend_cr_q[CR_PBE_BIT];
      protect_from_bottom <= protect_from_bottom | pend_cr_q[CR_TB_BIT];
      if (pend_cr_q[CR_ODS_MSB:CR_ODS_LSB] != ODS_RSVD_A &&
          pend_cr_q[CR_ODS_MSB:CR_ODS_LSB] != ODS_RSVD_B) begin
        drive_strength_code <= pend_cr_q[CR_ODS_MSB:CR_ODS_LSB];
      end
    end
  end

  // Wide addressing is command driven; the written data bit is ignored.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wide_address_flag <= 1'b0;
    end else if (frame_done && idle && fr_cnt == FRAME_CMD_BITS) begin
      if (fr_op == OP_ENTER_WIDE) begin
        wide_address_flag <= 1'b1;
      end else if (fr_op == OP_EXIT_WIDE) begin
        wide_address_flag <= 1'b0;
      end
    end
  end

  // Mode and dummy outputs are registered so every output but busy_flag, a decode of state_q, is a flop.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hw_protect_mode <= 1'b0;
      dummy_fast <= 4'h8;
      dummy_dual_io <= 4'h4;
      dummy_quad_io <= 4'h6;
    end else begin
      hw_protect_mode <= reg_write_lock && !wp_s &&
                         !quad_enable && !quad_peripheral_mode;
      dummy_fast <= dummy_lookup(DUMMY_FAST_TBL, dummy_count_sel);
      dummy_dual_io <= dummy_lookup(DUMMY_DUAL_IO_TBL, dummy_count_sel);
      dummy_quad_io <= dummy_lookup(DUMMY_QUAD_IO_TBL, dummy_count_sel);
    end
  end

  // Program and erase gate; the area decode itself lives outside.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pe_grant <= 1'b0;
      pe_refuse <= 1'b0;
    end else begin
      pe_grant <= pe_req && write_latch && idle && !pe_hits_protected;
      pe_refuse <= pe_req && (!write_latch || !idle || pe_hits_protected);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_q);
  busy_start_a: assert property (wr_valid |=> busy_flag ##1 busy_flag)
    else $error("Update cycle did not start after a valid write frame");
  busy_hold_a: assert property (busy_flag && upd_cnt_q != 24'h000000 |=> busy_flag)
    else $error("Busy dropped before the update timer expired");
  busy_end_a: assert property ($fell(busy_flag) |-> !write_latch)
    else $error("Write latch still set after update completion");
  hpm_track_a: assert property (hw_protect_mode ==
                                ($past(reg_write_lock) && !$past(wp_s) &&
                                 !$past(quad_enable) && !$past(quad_peripheral_mode)))
    else $error("Hardware protect mode does not follow lock, pin and quad state");
  hpm_reject_a: assert property (frame_done && idle && hw_protect_mode |=> !busy_flag)
    else $error("Write frame accepted in hardware protect mode");
  latch_gate_a: assert property (frame_done && idle && !write_latch |=> !busy_flag)
    else $error("Write frame accepted without the write latch");
  bad_count_a: assert property (frame_done && idle && fr_op == OP_WRITE_REGS &&
                                fr_cnt != FRAME_SR_BITS && fr_cnt != FRAME_CR_BITS |=> !busy_flag)
    else $error("Write frame of wrong length accepted");
  cfg_keep_a: assert property ($fell(busy_flag) && !$past(pend_has_cr_q) |->
                               $stable(drive_strength_code) && $stable(dummy_count_sel) &&
                               $stable(preamble_enable))
    else $error("Short write frame changed the configuration register");
  cfg_source_a: assert property ($changed(drive_strength_code) || $changed(preamble_enable) |->
                                 $past(wr_done))
    else $error("Configuration changed outside a write update");
  tb_otp_a: assert property ($past(protect_from_bottom) |-> protect_from_bottom)
    else $error("One-time top/bottom bit was cleared");
  pe_refuse_a: assert property (pe_req && (pe_hits_protected || !write_latch) |=>
                                pe_refuse && !pe_grant)
    else $error("Protected program or erase was not refused");
  wide_set_a: assert property (frame_done && idle && fr_cnt == FRAME_CMD_BITS &&
                               fr_op == OP_ENTER_WIDE |=> wide_address_flag)
    else $error("Enter-wide command did not set the wide address flag");

endmodule // fcw_top
`default_nettype wire

// *** sim/fcw_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host controller model; the serial clock only toggles inside a frame.
module fcw_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_o,
  input wire logic so_oe
);
  logic [7:0] rd_q;
  logic oe_q;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // Shift nbits out MSB first, then clock nrd bits back in on rising edges.
  task automatic xfer(input logic [31:0] bits, input int nbits, input int nrd);
    int i;
    cs_n = 1'b0;
    oe_q = 1'b1;
    #5;
    for (i = 0; i < nbits + nrd; i++) begin
      si = (i < nbits) ? bits[nbits-1-i] : ~si;
      #6 sclk = 1'b1;
      if (i >= nbits) begin
        rd_q = {rd_q[6:0], so_o};
        oe_q = oe_q & so_oe;
      end
      #6 sclk = 1'b0;
    end
    #5 cs_n = 1'b1;
    si = ~si;
    // The long gap keeps the frame bits stable until the core has taken them.
    #40;
  endtask
endmodule // fcw_host
`default_nettype wire

// *** sim/fcw_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcw_top_bench;
  import fcw_pkg::*;
  localparam int UPD = 100;
  logic clk, resetn, wp, qpm, pe_req, pe_hits;
  logic sclk, cs_n, si, so_o, so_oe, pe_grant, pe_refuse, busy_flag, write_latch;
  logic quad_enable, reg_write_lock, hw_protect_mode, protect_from_bottom;
  logic preamble_enable, wide_address_flag;
  logic [3:0] block_protect_level, dummy_fast, dummy_dual_io, dummy_quad_io;
  logic [2:0] drive_strength_code, ods_e;
  logic [1:0] dummy_count_sel;
  int err_total, total_checks, busy_run, busy_len, cyc;
  logic [2:0] ods_t [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
  logic [3:0] fast_t [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  logic [3:0] dual_t [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  logic [3:0] quad_t [4] = '{4'h6, 4'h4, 4'h8, 4'hA};

  fcw_top #(.UPDATE_CYCLES(UPD)) fcw_top_inst (.clk(clk), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe), .write_protect_pin(wp),
    .quad_peripheral_mode(qpm), .pe_req(pe_req), .pe_hits_protected(pe_hits),
    .pe_grant(pe_grant), .pe_refuse(pe_refuse), .busy_flag(busy_flag),
    .write_latch(write_latch), .block_protect_level(block_protect_level),
    .quad_enable(quad_enable), .reg_write_lock(reg_write_lock),
    .hw_protect_mode(hw_protect_mode), .protect_from_bottom(protect_from_bottom),
    .preamble_enable(preamble_enable), .wide_address_flag(wide_address_flag),
    .drive_strength_code(drive_strength_code), .dummy_count_sel(dummy_count_sel),
    .dummy_fast(dummy_fast), .dummy_dual_io(dummy_dual_io), .dummy_quad_io(dummy_quad_io));

  fcw_host fcw_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Length of the last busy pulse, so the update time can be compared.
  always @(posedge clk) begin
    if (busy_flag === 1'b1) begin
      busy_run <= busy_run + 1;
    end else begin
      if (busy_run != 0) busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  // A hang is cut short well past the expected run of a few thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    fcw_host_inst.xfer({24'h0, op}, 8, 0);
  endtask

  // Read one byte back and check that the output was enabled throughout.
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    fcw_host_inst.xfer({24'h0, op}, 8, 8);
    chk({8'h0, fcw_host_inst.rd_q}, {8'h0, exp}, "readback");
    chk({fcw_host_inst.oe_q, so_oe}, 2'b10, "output enable");
  endtask

  task automatic wait_idle();
    int i;
    repeat (4) @(posedge clk);
    @(negedge clk);
    for (i = 0; i < 400 && busy_flag !== 1'b0; i++) @(negedge clk);
    // Two more edges, so the busy length and the registered tables have settled.
    repeat (2) @(negedge clk);
  endtask

  // Write enable, then a write frame carrying n data bits.
  task automatic wr(input logic [15:0] d, input int n);
    cmd(OP_WRITE_ENABLE);
    fcw_host_inst.xfer({8'h0, {OP_WRITE_REGS, d} >> (16 - n)}, 8 + n, 0);
    wait_idle();
  endtask

  task automatic pe(input logic hits, input logic g);
    @(posedge clk);
    pe_req <= 1'b1;
    pe_hits <= hits;
    @(posedge clk);
    pe_req <= 1'b0;
    @(negedge clk);
    chk({pe_grant, pe_refuse}, {g, ~g}, "program gate");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    wp = 1'b1;
    qpm = 1'b0;
    pe_req = 1'b0;
    pe_hits = 1'b0;
    err_total = 0;
    total_checks = 0;
    busy_run = 0;
    busy_len = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    // Factory state of every field and table.
    chk({dummy_fast, dummy_dual_io, dummy_quad_io, 1'b0, drive_strength_code},
      16'h8467, "reset tables");
    chk({reg_write_lock, quad_enable, block_protect_level, write_latch, busy_flag,
      protect_from_bottom, preamble_enable, wide_address_flag}, 16'h0, "reset flags");
    rd(OP_READ_STATUS, 8'h00);
    rd(OP_READ_CONFIG, 8'h07);
    // A write frame without the latch set is ignored.
    fcw_host_inst.xfer({8'h0, OP_WRITE_REGS, 16'h3C00}, 24, 0);
    wait_idle();
    chk({busy_len[3:0], block_protect_level}, 8'h00, "write without latch");
    // Full write; busy is readable while the update runs.
    cmd(OP_WRITE_ENABLE);
    chk(write_latch, 1'b1, "latch set");
    fcw_host_inst.xfer({8'h0, OP_WRITE_REGS, 16'h7FFD}, 24, 0);
    rd(OP_READ_STATUS, 8'h03);
    wait_idle();
    chk(busy_len[15:0], 16'(UPD), "update length");
    rd(OP_READ_STATUS, 8'h7C);
    rd(OP_READ_CONFIG, 8'hDD);
    // Every dummy code, with reserved drive codes mixed in.
    ods_e = 3'h5;
    for (int k = 0; k < 4; k++) begin
      if (ods_t[k] != 3'h0 && ods_t[k] != 3'h4) ods_e = ods_t[k];
      wr({8'h7C, k[1:0], 1'b0, k[0], 1'b0, ods_t[k]}, 16);
      chk({dummy_fast, dummy_dual_io, dummy_quad_io}, {fast_t[k], dual_t[k], quad_t[k]},
        "dummy tables");
      chk({preamble_enable, protect_from_bottom, drive_strength_code}, {k[0], 1'b1, ods_e},
        "config fields");
    end
    // A status-only write leaves the configuration alone.
    wr(16'h0000, 8);
    rd(OP_READ_CONFIG, 8'hDE);
    rd(OP_READ_STATUS, 8'h00);
    // A frame ending off a byte boundary is rejected and keeps the latch.
    wr(16'h3C00, 12);
    chk({block_protect_level, write_latch, busy_flag}, 6'h02, "odd count");
    pe(1'b1, 1'b0);
    pe(1'b0, 1'b1);
    // Lock set with the pin high, then the pin low enters hardware protection.
    wr(16'h8000, 8);
    chk(reg_write_lock, 1'b1, "lock set");
    @(posedge clk);
    wp <= 1'b0;
    repeat (6) @(posedge clk);
    chk(hw_protect_mode, 1'b1, "hw protect on");
    // Clear the last busy length so a wrongly accepted update would show.
    busy_len = 0;
    wr(16'h0000, 8);
    chk({reg_write_lock, write_latch, busy_len[3:0]}, 6'h30, "locked write");
    qpm <= 1'b1;
    repeat (6) @(posedge clk);
    chk(hw_protect_mode, 1'b0, "quad mode");
    qpm <= 1'b0;
    wp <= 1'b1;
    repeat (6) @(posedge clk);
    chk(hw_protect_mode, 1'b0, "pin high");
    wr(16'h0000, 8);
    chk({reg_write_lock, write_latch}, 2'b00, "unlock");
    pe(1'b0, 1'b0);
    // Wide addressing follows its two commands only.
    cmd(OP_ENTER_WIDE);
    chk(wide_address_flag, 1'b1, "wide on");
    rd(OP_READ_CONFIG, 8'hFE);
    cmd(OP_EXIT_WIDE);
    chk(wide_address_flag, 1'b0, "wide off");
    final_report();
  end
endmodule // fcw_top_bench
`default_nettype wire
